// file: inc/spi_port_pkg.sv
// Purpose: Shared constants and types for the serial peripheral port.
// Assumes: One 20 MHz system clock; every serial pin is asynchronous to it.
// Notes: The port state is one packed record registered once per clock.
// Overview of operation
// (RL1) Slave enable raises a false receive-ready flag.
// (RL2) Software clears it by toggling polarity, reading.
// (RL3) Disable command is ignored in slave mode.
// (RL4) Software stops slave by reading, then soft reset.
// (RL5) Held select zero plus fault detection stalls start.
// (RL6) Software sets fault-detect disable when holding select.
// (RL7) Disabled port drops writes; transmit-empty flag untouched.
// (RL8) Writes after disable are accepted and lost.
// (RL9) Software stops DMA, waits, then disables port.
// (RL10) Slave mode never reports a transmit underrun.
// (RL11) Mixed divider one gives extra clock pulse.
// (RL12) Software gives all selects divider one together.
// (RL13) Reading holding register clears receive-ready; words set.
package spi_port_pkg;

  // Word width on the serial line and depth of the transmit FIFO.
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;

  // Counter limits of one word and of the extra pulse.
  localparam logic [3:0] LAST_EDGE  = 4'hf;
  localparam logic [3:0] LEAD_EDGES = 4'h1;
  localparam logic [2:0] LAST_BIT   = 3'h7;

  // Divider codes; a zero divider behaves as one.
  localparam logic [7:0] DIV_ZERO = 8'h00;
  localparam logic [7:0] DIV_ONE  = 8'h01;

  typedef logic [DATA_W-1:0] word_t;

  // Master sequencer, Gray coded along idle, lead, shift, done.
  typedef enum logic [1:0] {
    MST_IDLE  = 2'h0,
    MST_LEAD  = 2'h1,
    MST_SHIFT = 2'h3,
    MST_DONE  = 2'h2
  } master_state_e;

  // Settings of one chip select.
  typedef struct packed {
    logic       clock_idle_polarity;        // Idle level of the serial clock.
    logic       inverted_phase_select;      // One samples on the leading edge.
    logic       hold_select_after_transfer; // Keeps the select low afterwards.
    logic [7:0] serial_clock_divider;       // System clocks per half period.
  } chipselect_config_s;

  // Mode settings of the port.
  typedef struct packed {
    logic master_mode;          // One for master, zero for slave.
    logic fault_detect_disable; // One turns mode-fault detection off.
    logic chip_select_index;    // Select used by the next master transfer.
  } mode_reg_s;

  // One-cycle command strobes.
  typedef struct packed {
    logic enable_cmd;
    logic disable_cmd;
    logic soft_reset_bit;
  } control_reg_s;

  // Whole state of the port.
  typedef struct packed {
    master_state_e mst;
    logic          enabled;
    logic          mode_fault;
    logic          receive_ready_flag;
    logic          tx_empty_flag;
    word_t         receive_holding_reg;
    word_t         shifter;
    logic          out_bit;
    logic          sck;
    logic [3:0]    edge_idx;
    logic [7:0]    div_cnt;
    logic [2:0]    bit_cnt;
    logic          slv_pending;
    logic [1:0]    cs_n;
    logic          cur_cs;
    logic          have_prev;
    logic          prev_div_one;
    logic [1:0]    sck_sync;  // Meta stage, then stable stage.
    logic          sck_dly;   // Stable stage one clock older.
    logic [1:0]    mosi_sync;
    logic [1:0]    miso_sync;
    logic [1:0]    nss_sync;
  } port_state_s;

  localparam port_state_s PORT_STATE_RESET = '{
    mst:           MST_IDLE,
    tx_empty_flag: 1'h1,
    slv_pending:   1'h1,
    cs_n:          2'h3,
    nss_sync:      2'h3,
    default:       '0
  };

endpackage

// file: rtl/spi_tx_fifo.sv
// Purpose: Transmit FIFO between the data register and the shifter.
// Assumes: Writer and reader share one clock.
// Notes: Flush empties it in one clock; stored words are not cleared.
`timescale 1ns/1ns
module spi_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  // Pointers and fill level travel together.
  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_s;

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
  fifo_state_s      state_ff;     // Registered pointers.
  fifo_state_s      nxt_state;    // Next pointers.
  logic             push;         // A word is written this clock.
  logic             pop;          // A word is taken this clock.

  // Full and empty come straight from the count, so they never lie.
  assign in_ready  = (state_ff.count != CNT_FULL);
  assign out_valid = (state_ff.count != '0);
  assign out_data  = mem[state_ff.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer arithmetic, wrapping at the last slot.
  always_comb
  begin
    nxt_state = state_ff;
    if (push)
    begin
      nxt_state.wr_ptr = (state_ff.wr_ptr == PTR_LAST) ? '0 : state_ff.wr_ptr + 1'h1;
    end
    if (pop)
    begin
      nxt_state.rd_ptr = (state_ff.rd_ptr == PTR_LAST) ? '0 : state_ff.rd_ptr + 1'h1;
    end
    nxt_state.count = state_ff.count + CW'(push) - CW'(pop);
    if (flush)
    begin
      nxt_state = '0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Storage needs no reset; the count guards stale words.
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[state_ff.wr_ptr] <= in_data;
    end
  end

endmodule // spi_tx_fifo

// file: rtl/spi_port.sv
// Purpose: Serial peripheral port, master or slave, with its known quirks kept.
// Assumes: SYS_CLK at 20 MHz; pins are synchronised before use.
// Notes: Slave serial clock must stay below one eighth of SYS_CLK.
`timescale 1ns/1ns
module spi_port (
  input  wire logic                            SYS_CLK,
  input  wire logic                            RST,
  input  wire spi_port_pkg::control_reg_s      CONTROL_REG,
  input  wire spi_port_pkg::mode_reg_s         MODE_REG,
  input  wire spi_port_pkg::chipselect_config_s CHIPSELECT0_CONFIG,
  input  wire spi_port_pkg::chipselect_config_s CHIPSELECT1_CONFIG,
  input  wire logic                            TX_DATA_VALID,
  input  wire spi_port_pkg::word_t             TX_DATA_REG,
  output logic                                 TX_DATA_READY,
  input  wire logic                            RX_READ,
  output spi_port_pkg::word_t                  RECEIVE_HOLDING_REG,
  output logic                                 RECEIVE_READY_FLAG,
  output logic                                 TX_EMPTY_FLAG,
  output logic                                 PORT_ENABLED,
  output logic                                 MODE_FAULT,
  input  wire logic                            SCK_IN,
  output logic                                 SCK_OUT,
  output logic                                 SCK_OE,
  input  wire logic                            MOSI_IN,
  output logic                                 MOSI_OUT,
  output logic                                 MOSI_OE,
  input  wire logic                            MISO_IN,
  output logic                                 MISO_OUT,
  output logic                                 MISO_OE,
  input  wire logic                            NSS_IN,
  output logic [1:0]                           CS_N
);
  import spi_port_pkg::*;

  port_state_s        state_ff;     // Registered state.
  port_state_s        nxt_state;    // Next state.
  chipselect_config_s cfg;          // Settings of the select in use.
  chipselect_config_s slv_cfg;      // Slave always runs on select zero.
  logic               fifo_push;    // Accepted write into the FIFO.
  logic               fifo_pop;     // Word moved into the shifter.
  logic               fifo_in_rdy;  // FIFO has room.
  logic               fifo_valid;   // FIFO holds a word.
  word_t              fifo_data;    // Oldest FIFO word.
  logic               sck_s;        // Synchronised serial clock.
  logic               nss_s;        // Synchronised slave select.
  logic               slv_active;   // Slave selected and enabled.
  logic               slv_edge;     // Serial clock changed level.
  logic               leading;      // Current edge leaves the idle level.
  logic               sample;       // Current edge samples the data line.
  logic               start_ok;     // A master transfer may begin.
  logic               extra_pulse;  // Divider mix asks for a stray pulse.
  logic [7:0]         div_load;     // Reload value of the divider.

  // A zero divider is treated as one; used for reloads and comparisons.
  function automatic logic [7:0] eff_div(input logic [7:0] d);
    eff_div = (d == DIV_ZERO) ? DIV_ONE : d;
  endfunction

  // Picks the settings of one chip select.
  function automatic chipselect_config_s pick_cfg(input logic idx,
                                                  input chipselect_config_s c0,
                                                  input chipselect_config_s c1);
    pick_cfg = idx ? c1 : c0;
  endfunction

  // Disabled: writes are dropped but still acknowledged, so a DMA source keeps
  // pushing until its buffer is empty and every such word is lost.
  assign fifo_push     = TX_DATA_VALID & state_ff.enabled;        // (RL7)
  assign TX_DATA_READY = state_ff.enabled ? fifo_in_rdy : 1'h1;   // (RL8)

  spi_tx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) spi_tx_fifo_i (
    .sys_clk   (SYS_CLK),
    .rst       (RST),
    .flush     (CONTROL_REG.soft_reset_bit),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_rdy),
    .in_data   (TX_DATA_REG),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Stable synchroniser stages only; the meta stages feed nothing else.
  assign sck_s      = state_ff.sck_sync[1];
  assign nss_s      = state_ff.nss_sync[1];
  assign slv_cfg    = CHIPSELECT0_CONFIG;
  assign slv_active = state_ff.enabled & ~MODE_REG.master_mode & ~nss_s;
  assign slv_edge   = sck_s ^ state_ff.sck_dly;

  // Settings follow the latched select while busy, the requested one when idle.
  assign cfg = pick_cfg((state_ff.mst == MST_IDLE) ? MODE_REG.chip_select_index
                                                   : state_ff.cur_cs,
                        CHIPSELECT0_CONFIG, CHIPSELECT1_CONFIG);
  assign div_load = eff_div(cfg.serial_clock_divider) - DIV_ONE;

  // Held select zero with fault detection on never lets a transfer begin.
  assign start_ok = ~(CHIPSELECT0_CONFIG.hold_select_after_transfer
                      & ~MODE_REG.fault_detect_disable);          // (RL5)

  // Switching between a divider of one and any other divider with idle-high
  // clock and phase bit zero adds one stray clock pulse before the word.
  assign extra_pulse = state_ff.have_prev & cfg.clock_idle_polarity
                       & ~cfg.inverted_phase_select
                       & (state_ff.prev_div_one
                          != (eff_div(cfg.serial_clock_divider) == DIV_ONE)); // (RL11)

  // Next-state logic of the whole port.
  always_comb
  begin
    nxt_state = state_ff;
    fifo_pop  = 1'h0;
    leading   = 1'h0;
    sample    = 1'h0;

    // Synchronisers: pin, meta stage, stable stage, edge delay.
    nxt_state.sck_sync  = {state_ff.sck_sync[0], SCK_IN};
    nxt_state.sck_dly   = state_ff.sck_sync[1];
    nxt_state.mosi_sync = {state_ff.mosi_sync[0], MOSI_IN};
    nxt_state.miso_sync = {state_ff.miso_sync[0], MISO_IN};
    nxt_state.nss_sync  = {state_ff.nss_sync[0], NSS_IN};

    // Reading the holding register clears the flag; a set below wins.
    if (RX_READ)
    begin
      nxt_state.receive_ready_flag = 1'h0;                        // (RL13)
    end

    // Empty flag tracks the FIFO only while enabled; frozen when disabled.
    if (state_ff.enabled)
    begin
      nxt_state.tx_empty_flag = ~fifo_valid & ~fifo_push;
    end
    else
    begin
      nxt_state.tx_empty_flag = state_ff.tx_empty_flag;           // (RL7)
    end

    // Enable; in slave mode the enable itself leaves a false ready flag.
    if (CONTROL_REG.enable_cmd)
    begin
      nxt_state.enabled    = 1'h1;
      nxt_state.mode_fault = 1'h0;
      if (!MODE_REG.master_mode)
      begin
        nxt_state.receive_ready_flag = 1'h1;                      // (RL1)
      end
    end

    // Disable acts in master mode only; a slave keeps running.
    if (CONTROL_REG.disable_cmd && MODE_REG.master_mode)
    begin
      nxt_state.enabled = 1'h0;                                   // (RL3)
      nxt_state.mst     = MST_IDLE;
      nxt_state.cs_n    = 2'h3;
    end

    // Master datapath.
    unique case (state_ff.mst)
      MST_IDLE:
      begin
        nxt_state.sck = cfg.clock_idle_polarity;
        if (state_ff.enabled && MODE_REG.master_mode && fifo_valid && start_ok
            && !CONTROL_REG.disable_cmd)                          // (RL5)
        begin
          fifo_pop               = 1'h1;
          nxt_state.shifter      = fifo_data;
          nxt_state.out_bit      = fifo_data[DATA_W-1];
          nxt_state.cur_cs       = MODE_REG.chip_select_index;
          nxt_state.cs_n         = MODE_REG.chip_select_index ? 2'h1 : 2'h2;
          nxt_state.div_cnt      = div_load;
          nxt_state.edge_idx     = '0;
          nxt_state.mst          = extra_pulse ? MST_LEAD : MST_SHIFT; // (RL11)
        end
      end
      MST_LEAD:
      begin
        // Stray pulse: the clock dips low and returns before the word.
        if (state_ff.div_cnt == DIV_ZERO)
        begin
          nxt_state.div_cnt  = div_load;
          nxt_state.sck      = ~state_ff.sck;                     // (RL11)
          nxt_state.edge_idx = state_ff.edge_idx + 1'h1;
          if (state_ff.edge_idx == LEAD_EDGES)
          begin
            nxt_state.edge_idx = '0;
            nxt_state.mst      = MST_SHIFT;
          end
        end
        else
        begin
          nxt_state.div_cnt = state_ff.div_cnt - DIV_ONE;
        end
      end
      MST_SHIFT:
      begin
        if (state_ff.div_cnt == DIV_ZERO)
        begin
          nxt_state.div_cnt  = div_load;
          nxt_state.sck      = ~state_ff.sck;
          leading            = ~state_ff.edge_idx[0];
          sample             = (leading == cfg.inverted_phase_select);
          if (sample)
          begin
            nxt_state.shifter = {state_ff.shifter[DATA_W-2:0], state_ff.miso_sync[1]};
          end
          else
          begin
            nxt_state.out_bit = state_ff.shifter[DATA_W-1];
          end
          nxt_state.edge_idx = state_ff.edge_idx + 1'h1;
          if (state_ff.edge_idx == LAST_EDGE)
          begin
            nxt_state.mst = MST_DONE;
          end
        end
        else
        begin
          nxt_state.div_cnt = state_ff.div_cnt - DIV_ONE;
        end
      end
      MST_DONE:
      begin
        nxt_state.receive_holding_reg = state_ff.shifter;
        nxt_state.receive_ready_flag  = 1'h1;                     // (RL13)
        nxt_state.have_prev           = 1'h1;
        nxt_state.prev_div_one        = (eff_div(cfg.serial_clock_divider) == DIV_ONE);
        if (!cfg.hold_select_after_transfer)
        begin
          nxt_state.cs_n = 2'h3;
        end
        nxt_state.mst = MST_IDLE;
      end
    endcase

    // Mode fault: another master pulls the select low while we drive.
    if (state_ff.enabled && MODE_REG.master_mode && !MODE_REG.fault_detect_disable
        && !nss_s)
    begin
      nxt_state.mode_fault = 1'h1;
      nxt_state.enabled    = 1'h0;
      nxt_state.mst        = MST_IDLE;
      nxt_state.cs_n       = 2'h3;
    end

    // Slave datapath; an empty FIFO sends zeros and nothing reports it.
    if (!slv_active)
    begin
      nxt_state.bit_cnt     = '0;
      nxt_state.slv_pending = 1'h1;
    end
    else if (state_ff.slv_pending)
    begin
      nxt_state.slv_pending = 1'h0;
      fifo_pop              = fifo_valid;
      nxt_state.shifter     = fifo_valid ? fifo_data : '0;        // (RL10)
      nxt_state.out_bit     = fifo_valid ? fifo_data[DATA_W-1] : 1'h0;
    end
    else if (slv_edge)
    begin
      leading = (state_ff.sck_dly == slv_cfg.clock_idle_polarity);
      sample  = (leading == slv_cfg.inverted_phase_select);
      if (sample)
      begin
        nxt_state.shifter = {state_ff.shifter[DATA_W-2:0], state_ff.mosi_sync[1]};
        nxt_state.bit_cnt = state_ff.bit_cnt + 1'h1;
        if (state_ff.bit_cnt == LAST_BIT)
        begin
          nxt_state.receive_holding_reg = {state_ff.shifter[DATA_W-2:0],
                                           state_ff.mosi_sync[1]};
          nxt_state.receive_ready_flag  = 1'h1;                   // (RL13)
          nxt_state.slv_pending         = 1'h1;
        end
      end
      else
      begin
        nxt_state.out_bit = state_ff.shifter[DATA_W-1];
      end
    end

    // Soft reset is the only way to stop a slave; it restarts everything.
    if (CONTROL_REG.soft_reset_bit)
    begin
      nxt_state = PORT_STATE_RESET;                               // (RL4)
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff <= PORT_STATE_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come from the state register; enables follow the mode.
  assign RECEIVE_HOLDING_REG = state_ff.receive_holding_reg;
  assign RECEIVE_READY_FLAG  = state_ff.receive_ready_flag;
  assign TX_EMPTY_FLAG       = state_ff.tx_empty_flag;
  assign PORT_ENABLED        = state_ff.enabled;
  assign MODE_FAULT          = state_ff.mode_fault;
  assign SCK_OUT             = state_ff.sck;
  assign SCK_OE              = state_ff.enabled & MODE_REG.master_mode;
  assign MOSI_OUT            = state_ff.out_bit;
  assign MOSI_OE             = state_ff.enabled & MODE_REG.master_mode;
  assign MISO_OUT            = state_ff.out_bit;
  assign MISO_OE             = slv_active;
  assign CS_N                = state_ff.cs_n;

endmodule // spi_port

// file: test/spi_port_sva.sv
// Purpose: Port-level assertions for the serial peripheral port.
// Assumes: One clock domain; RST is asynchronous and active high.
// Notes: Receive-clear check only runs while the slave is deselected.
`timescale 1ns/1ns
module spi_port_sva
  import spi_port_pkg::*;
(
  input wire logic               SYS_CLK,
  input wire logic               RST,
  input wire control_reg_s       CONTROL_REG,
  input wire mode_reg_s          MODE_REG,
  input wire chipselect_config_s CHIPSELECT0_CONFIG,
  input wire logic               TX_DATA_READY,
  input wire logic               RX_READ,
  input wire logic               RECEIVE_READY_FLAG,
  input wire logic               TX_EMPTY_FLAG,
  input wire logic               PORT_ENABLED,
  input wire logic               SCK_OE,
  input wire logic               MOSI_OE,
  input wire logic               MISO_OE,
  input wire logic               NSS_IN,
  input wire logic [1:0]         CS_N
);
  // All checks share the system clock and drop out during reset.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_slave_enable_flag: assert property (
    CONTROL_REG.enable_cmd && !CONTROL_REG.soft_reset_bit && !MODE_REG.master_mode
    |=> PORT_ENABLED && RECEIVE_READY_FLAG) else $error("slave enable without flag");
  a_slave_disable_ignored: assert property (
    PORT_ENABLED && !MODE_REG.master_mode && !CONTROL_REG.soft_reset_bit
    |=> PORT_ENABLED) else $error("slave port stopped by disable");
  a_soft_reset_stop: assert property (
    CONTROL_REG.soft_reset_bit |=> !PORT_ENABLED && TX_EMPTY_FLAG
    && !RECEIVE_READY_FLAG && CS_N == 2'h3) else $error("soft reset incomplete");
  a_hold_stall: assert property (
    PORT_ENABLED && MODE_REG.master_mode
    && CHIPSELECT0_CONFIG.hold_select_after_transfer && !MODE_REG.fault_detect_disable
    && CS_N == 2'h3 |=> CS_N == 2'h3) else $error("transfer started with held select");
  a_empty_frozen: assert property (
    !PORT_ENABLED && !CONTROL_REG.enable_cmd && !CONTROL_REG.soft_reset_bit
    |=> $stable(TX_EMPTY_FLAG)) else $error("empty flag moved while disabled");
  a_ready_when_off: assert property (
    !PORT_ENABLED |-> TX_DATA_READY && !SCK_OE && !MOSI_OE && !MISO_OE)
    else $error("disabled port refused write or drove pins");
  a_off_selects: assert property (
    !PORT_ENABLED |=> CS_N == 2'h3) else $error("select low while disabled");
  a_read_clears: assert property (
    RX_READ && !CONTROL_REG.enable_cmd && !MODE_REG.master_mode && NSS_IN
    && $past(NSS_IN, 4) |=> !RECEIVE_READY_FLAG) else $error("read left flag set");
endmodule // spi_port_sva

bind spi_port spi_port_sva spi_port_sva_i (.SYS_CLK, .RST, .CONTROL_REG, .MODE_REG,
  .CHIPSELECT0_CONFIG, .TX_DATA_READY, .RX_READ, .RECEIVE_READY_FLAG, .TX_EMPTY_FLAG,
  .PORT_ENABLED, .SCK_OE, .MOSI_OE, .MISO_OE, .NSS_IN, .CS_N);

// file: test/spi_peer_model.sv
// Purpose: External serial device facing the port, master or slave.
// Assumes: Peer master uses idle-low clock, sampling on the rising edge.
// Notes: Half period 300 ns keeps the clock well below an eighth of SYS_CLK.
`timescale 1ns/1ns
module spi_peer_model (
  input wire logic [1:0] CS_N,
  input wire logic       MISO_OUT,
  output logic           SCK_IN,
  output logic           MOSI_IN,
  output logic           NSS_IN,
  output logic           MISO_IN
);
  logic pat = 1'h0; // Stands in for a released line, so stale data never looks valid.

  // Free pattern for the undriven slave output.
  always #50 pat = ~pat;

  // As a slave, answers ones while selected and floats otherwise.
  assign MISO_IN = (CS_N != 2'h3) ? 1'h1 : pat;

  initial
  begin
    SCK_IN  = 1'h0;
    MOSI_IN = 1'h0;
    NSS_IN  = 1'h1;
  end

  // One master frame: clock stands still outside it, data inverted after it.
  task automatic send(input logic [7:0] tx, output logic [7:0] rx);
    NSS_IN = 1'h0;
    #600;
    for (int i = 7; i >= 0; i--)
    begin
      MOSI_IN = tx[i];
      #300 SCK_IN = 1'h1;
      rx[i] = MISO_OUT;
      #300 SCK_IN = 1'h0;
    end
    #600 NSS_IN = 1'h1;
    MOSI_IN = ~MOSI_IN;
  endtask
endmodule // spi_peer_model

// file: test/spi_port_tb.sv
// Purpose: Self-checking bench for the serial peripheral port.
// Assumes: Inputs change 2 ns after the rising clock edge.
// Notes: Slave clock from the peer model; master data comes back as ones.
`timescale 1ns/1ns
module spi_port_tb;
  import spi_port_pkg::*;
  logic               sys_clk = 1'h0;
  logic               rst = 1'h1;
  control_reg_s       ctl = '0;
  mode_reg_s          mode = '0;
  chipselect_config_s cs0 = '0;
  chipselect_config_s cs1 = '0;
  logic               tx_valid = 1'h0;
  word_t              tx_data = '0;
  logic               rx_read = 1'h0;
  logic               tx_ready, rx_flag, tx_empty, enabled, sck_out, miso_out, mosi_out;
  logic               sck_in, mosi_in, nss_in, miso_in;
  word_t              rx_word, mosi_word;
  logic [1:0]         cs_n;
  logic [7:0]         got;
  int                 failures = 0;
  int                 samples_checked = 0;
  int                 toggles = 0;
  bit                 counting = 1'b0;

  // 20 MHz system clock.
  always #25 sys_clk = ~sys_clk;

  // Counts serial clock edges while measuring; rising edges rebuild the master word.
  always @(sck_out) if (counting) toggles++;
  always @(posedge sck_out) mosi_word = {mosi_word[6:0], mosi_out};

  spi_port spi_port_i (.SYS_CLK(sys_clk), .RST(rst), .CONTROL_REG(ctl), .MODE_REG(mode),
    .CHIPSELECT0_CONFIG(cs0), .CHIPSELECT1_CONFIG(cs1), .TX_DATA_VALID(tx_valid),
    .TX_DATA_REG(tx_data), .TX_DATA_READY(tx_ready), .RX_READ(rx_read),
    .RECEIVE_HOLDING_REG(rx_word), .RECEIVE_READY_FLAG(rx_flag), .TX_EMPTY_FLAG(tx_empty),
    .PORT_ENABLED(enabled), .MODE_FAULT(), .SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(),
    .MOSI_IN(mosi_in), .MOSI_OUT(mosi_out), .MOSI_OE(), .MISO_IN(miso_in), .MISO_OUT(miso_out),
    .MISO_OE(), .NSS_IN(nss_in), .CS_N(cs_n));

  spi_peer_model spi_peer_model_i (.CS_N(cs_n), .MISO_OUT(miso_out), .SCK_IN(sck_in),
    .MOSI_IN(mosi_in), .NSS_IN(nss_in), .MISO_IN(miso_in));

  // Compares one value, counting every compare and every mismatch.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Steps whole cycles and lands just after the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic cmd(input logic [2:0] c);
    ctl = c;
    tick(1);
    ctl = '0;
  endtask

  task automatic put(input word_t d);
    tx_valid = 1'h1;
    tx_data  = d;
    tick(1);
    tx_valid = 1'h0;
  endtask

  task automatic read_rx;
    rx_read = 1'h1;
    tick(1);
    rx_read = 1'h0;
  endtask

  // Bounded wait for a received word; running out counts as a mismatch.
  task automatic wait_flag;
    int i;
    i = 0;
    do
    begin
      tick(1);
      i++;
    end while (rx_flag !== 1'h1 && i < 4000);
    if (i >= 4000) failures++;
  endtask

  task automatic t_reset_and_off;
    check(tx_empty, 1'h1, "tx_empty");
    check(cs_n, 2'h3, "cs_n");
    for (int k = 0; k < 3; k++)
    begin
      tx_valid = 1'h1;
      tx_data  = 8'h10 + 8'(k);
      check(tx_ready, 1'h1, "tx_ready off");
      tick(1);
    end
    tx_valid = 1'h0;
    tick(1);
    check(tx_empty, 1'h1, "tx_empty off");
  endtask

  // Slave: false flag, workaround, data both ways, ignored disable, soft reset.
  task automatic t_slave;
    cs0 = '{1'h0, 1'h1, 1'h0, 8'h04};
    cmd(3'h4);
    check(enabled, 1'h1, "enabled");
    check(rx_flag, 1'h1, "false flag");
    cs0.clock_idle_polarity = 1'h1;
    tick(1);
    cs0.clock_idle_polarity = 1'h0;
    tick(1);
    read_rx;
    check(rx_flag, 1'h0, "flag after read");
    put(8'h3c);
    check(tx_empty, 1'h0, "tx_empty on");
    spi_peer_model_i.send(8'ha5, got);
    wait_flag;
    check(rx_word, 8'ha5, "rx word");
    check(got, 8'h3c, "slave out");
    cmd(3'h2);
    check(enabled, 1'h1, "slave disable");
    read_rx;
    spi_peer_model_i.send(8'h5a, got);
    wait_flag;
    check(got, 8'h00, "underrun word");
    check(rx_word, 8'h5a, "rx word 2");
    read_rx;
    cmd(3'h1);
    check(enabled, 1'h0, "soft reset");
  endtask

  // Master: held-select stall, its workaround, extra pulse, then disable.
  task automatic t_master;
    mode = '{1'h1, 1'h0, 1'h0};
    cs0  = '{1'h0, 1'h1, 1'h1, 8'h04};
    cmd(3'h4);
    put(8'h96);
    tick(100);
    check(cs_n, 2'h3, "stalled");
    mode.fault_detect_disable = 1'h1;
    wait_flag;
    check(rx_word, 8'hff, "master rx");
    check(cs_n, 2'h2, "held select");
    check(mosi_word, 8'h96, "master out");
    read_rx;
    cs0 = '{1'h1, 1'h0, 1'h0, 8'h01};
    cs1 = '{1'h1, 1'h0, 1'h0, 8'h01};
    mode.chip_select_index = 1'h1;
    put(8'h01);
    wait_flag;
    read_rx;
    mode.chip_select_index = 1'h0;
    toggles  = 0;
    counting = 1'b1;
    put(8'h02);
    wait_flag;
    read_rx;
    check(8'(toggles), 8'h10, "even edges");
    cs0.serial_clock_divider = 8'h04;
    toggles  = 0;
    put(8'h02);
    wait_flag;
    counting = 1'b0;
    check(8'(toggles), 8'h12, "sck edges");
    read_rx;
    cmd(3'h2);
    check(enabled, 1'h0, "master disable");
    put(8'h77);
    check(tx_empty, 1'h1, "dropped write");
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset.
  initial
  begin
    tick(5);
    rst = 1'h0;
    tick(1);
    t_reset_and_off;
    t_slave;
    t_master;
    end_of_test;
  end

  // Watchdog well beyond the expected run of about 28 us.
  initial
  begin
    #3000000;
    failures++;
    end_of_test;
  end
endmodule // spi_port_tb
